// [dld_regs.vh]
/*
  constants for the dual line driver control block: output style codes,
  pull-current field layout and timing figures.
  assumes a 20 MHz system clock.
*/
`ifndef DLD_REGS_VH
`define DLD_REGS_VH

// driver output style codes
`define DLD_STYLE_W        2
`define DLD_STYLE_SOURCE   2'h0
`define DLD_STYLE_SINK     2'h1
`define DLD_STYLE_PUSHPULL 2'h2

// pull-current field layout inside a driver configuration word
`define DLD_CFG_W          4
`define DLD_CFG_STYLE_LSB  0
`define DLD_CFG_PULLUP     2
`define DLD_CFG_PULLDN     3

// reset value of the driver configuration words (source, no pulls)
`define DLD_CFG_RESET      4'h0

// clock and short-circuit blanking interval
`define DLD_CLK_HZ         20000000
`define DLD_BLANK_US       128
`define DLD_BLANK_CYC      ((`DLD_BLANK_US * (`DLD_CLK_HZ / 1000000)))

`endif

// [dld_line_driver_control.v]
/*
  decision logic for the two line drivers (line port and auxiliary output)
  and the lamp driver: strap versus serial-configured control, driver
  style, enables, levels and the shared-port role selection.
  assumes the serial register file lives outside and presents its bits as
  plain ports on i_clk; pins from outside pass a two-stage synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dld_regs.vh"

module dld_line_driver_control #(
  parameter BLANK_CYCLES = `DLD_BLANK_CYC
) (
  input  wire                    i_clk,
  input  wire                    i_srst,
  // pins from the host
  input  wire                    i_interface_select,
  input  wire                    i_select_or_totem_strap,
  input  wire                    i_serial_in_sink_strap,
  input  wire                    i_clock_enable_limit_pin,
  input  wire                    i_aux_level_in,
  input  wire                    i_serial_role_select,
  input  wire                    i_lamp_input,
  // serial-configured bits from the register file
  input  wire [`DLD_CFG_W-1:0]   i_line_cfg_reg,
  input  wire [`DLD_CFG_W-1:0]   i_aux_cfg_reg,
  input  wire                    i_line_driver_off,
  input  wire                    i_line_level_bit,
  input  wire                    i_aux_driver_off,
  input  wire                    i_aux_level_bit,
  input  wire                    i_shared_port_enable,
  input  wire                    i_shared_port_variant,
  input  wire                    i_lamp_force_bit,
  input  wire                    i_rx_disable_bit,
  input  wire                    i_aux_in_disable_bit,
  input  wire                    i_deglitch_disable_bit,
  input  wire                    i_auto_retry_bit,
  input  wire [15:0]             i_blank_cycles_cfg,
  input  wire                    i_fault_alert,
  // line port driver (open-drain style pin, oe low while driving)
  output reg                     o_line_drive,
  output reg                     o_line_oe_n,
  output reg                     o_line_pullup_en,
  output reg                     o_line_pulldn_en,
  output reg                     o_line_power_down,
  // auxiliary output driver
  output reg                     o_aux_drive,
  output reg                     o_aux_oe_n,
  output reg                     o_aux_pullup_en,
  output reg                     o_aux_pulldn_en,
  output reg                     o_aux_power_down,
  // receive side, protection and lamp
  output reg                     o_rx_enable,
  output reg                     o_aux_input_enable,
  output reg                     o_deglitch_enable,
  output reg                     o_auto_retry_enable,
  output reg  [15:0]             o_blank_cycles,
  output reg                     o_serial_slave_active,
  output reg                     o_uart_active,
  output reg                     o_alert_overcurrent_n,
  output reg                     o_lamp_on
);

  // two-stage synchronisers for every pin, one generate loop
  localparam NPIN = 7;
  wire [NPIN-1:0] pin_raw;
  reg  [NPIN-1:0] pin_meta;
  reg  [NPIN-1:0] pin_sync;
  assign pin_raw = {i_lamp_input, i_serial_role_select, i_aux_level_in,
                    i_clock_enable_limit_pin, i_serial_in_sink_strap,
                    i_select_or_totem_strap, i_interface_select};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      always @(posedge i_clk) begin
        if (i_srst) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  wire serial_mode = pin_sync[0];   // high: serial configured
  wire totem_strap = pin_sync[1];
  wire sink_strap  = pin_sync[2];   // also transmit data
  wire transmit_drive_enable_pin    = pin_sync[3];   // also transmit drive enable
  wire aux_level   = pin_sync[4];
  wire role_sel    = pin_sync[5];
  wire lamp_pin    = pin_sync[6];

  // falling-edge detect of role select, on synchronised copies only
  reg role_sel_d;
  reg latched_transmit_drive_enable;
  reg latched_tx;
  always @(posedge i_clk) begin
    if (i_srst) begin
      role_sel_d   <= 1'b0;
      latched_transmit_drive_enable <= 1'b0;
      latched_tx   <= 1'b1;   // driver off until first capture
    end else begin
      role_sel_d <= role_sel;
      if (role_sel_d && !role_sel) begin
        latched_transmit_drive_enable <= transmit_drive_enable_pin;
        latched_tx   <= sink_strap;
      end
    end
  end

  // shared-port role selection and effective transmit levels
  reg shared_uart;
  reg eff_transmit_drive_enable;
  reg eff_tx;
  always @* begin
    shared_uart = 1'b0;
    eff_transmit_drive_enable    = transmit_drive_enable_pin;
    eff_tx      = sink_strap;
    if (serial_mode && i_shared_port_enable) begin
      if (!i_shared_port_variant) begin
        shared_uart = totem_strap;
      end else begin
        shared_uart = role_sel;
        // in the detect cycle the live pins equal what is being latched
        if (!role_sel && !role_sel_d) begin
          eff_transmit_drive_enable = latched_transmit_drive_enable;
          eff_tx   = latched_tx;
        end
      end
    end
  end

  // strap-selected style
  reg [`DLD_STYLE_W-1:0] strap_style;
  always @* begin
    if (totem_strap)
      strap_style = `DLD_STYLE_PUSHPULL;
    else if (sink_strap)
      strap_style = `DLD_STYLE_SINK;
    else
      strap_style = `DLD_STYLE_SOURCE;
  end

  // per-driver decision: en (drive), lvl (pin-side level source), style
  function [1:0] dld_drive;   // {oe_active, drive_value}
    input [`DLD_STYLE_W-1:0] style;
    input                    en;
    input                    lvl;
    reg                      want;
    begin
      want = ~lvl;
      dld_drive = 2'h0;
      if (en) begin
        case (style)
          `DLD_STYLE_SINK:     dld_drive = want ? 2'h0 : 2'h2;
          `DLD_STYLE_SOURCE:   dld_drive = want ? 2'h3 : 2'h0;
          `DLD_STYLE_PUSHPULL: dld_drive = {1'b1, want};
          default:             dld_drive = 2'h0;
        endcase
      end
    end
  endfunction

  // combinational driver decisions, registered once at the output
  reg [1:0] line_d;
  reg [1:0] aux_d;
  reg [`DLD_STYLE_W-1:0] line_style;
  reg [`DLD_STYLE_W-1:0] aux_style;
  always @* begin
    line_style = strap_style;
    aux_style  = strap_style;
    if (!serial_mode) begin
      line_d = dld_drive(strap_style, transmit_drive_enable_pin, sink_strap);
      aux_d  = dld_drive(strap_style, 1'b1, aux_level);
    end else begin
      line_style = i_line_cfg_reg[`DLD_CFG_STYLE_LSB +: `DLD_STYLE_W];
      aux_style  = i_aux_cfg_reg[`DLD_CFG_STYLE_LSB +: `DLD_STYLE_W];
      if (i_line_driver_off)
        line_d = 2'h0;
      else if (i_line_level_bit)
        line_d = dld_drive(line_style, 1'b1, 1'b0);
      else if (shared_uart || !i_shared_port_enable || i_shared_port_variant)
        line_d = dld_drive(line_style, eff_transmit_drive_enable, eff_tx);
      else
        line_d = 2'h0;  // variant 0 slave role: shared pins carry serial data
      if (i_aux_driver_off)
        aux_d = 2'h0;
      else if (i_aux_level_bit)
        aux_d = dld_drive(aux_style, 1'b1, 1'b0);
      else
        aux_d = dld_drive(aux_style, 1'b1, aux_level);
    end
  end

  // output stage; one cycle after the synchronisers
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_line_drive          <= 1'b0;
      o_line_oe_n           <= 1'b1;
      o_line_pullup_en      <= 1'b0;
      o_line_pulldn_en      <= 1'b0;
      o_line_power_down     <= 1'b0;
      o_aux_drive           <= 1'b0;
      o_aux_oe_n            <= 1'b1;
      o_aux_pullup_en       <= 1'b0;
      o_aux_pulldn_en       <= 1'b0;
      o_aux_power_down      <= 1'b0;
      o_rx_enable           <= 1'b1;
      o_aux_input_enable    <= 1'b1;
      o_deglitch_enable     <= 1'b1;
      o_auto_retry_enable   <= 1'b0;
      o_blank_cycles        <= BLANK_CYCLES[15:0];
      o_serial_slave_active <= 1'b0;
      o_uart_active         <= 1'b0;
      o_alert_overcurrent_n <= 1'b1;
      o_lamp_on             <= 1'b0;
    end else begin
      o_line_oe_n  <= ~line_d[1];
      o_line_drive <= line_d[0];
      o_aux_oe_n   <= ~aux_d[1];
      o_aux_drive  <= aux_d[0];
      o_line_power_down <= serial_mode & i_line_driver_off;
      o_aux_power_down  <= serial_mode & i_aux_driver_off;
      if (!serial_mode) begin
        o_line_pullup_en    <= 1'b0;
        o_line_pulldn_en    <= 1'b0;
        o_aux_pullup_en     <= 1'b0;
        o_aux_pulldn_en     <= 1'b0;
        o_auto_retry_enable <= 1'b0;
        o_rx_enable         <= 1'b1;
        o_aux_input_enable  <= 1'b1;
        o_deglitch_enable   <= 1'b1;
        o_blank_cycles      <= BLANK_CYCLES[15:0];
        o_serial_slave_active <= 1'b0;
        o_uart_active         <= 1'b0;
      end else begin
        o_line_pullup_en    <= i_line_cfg_reg[`DLD_CFG_PULLUP];
        o_line_pulldn_en    <= i_line_cfg_reg[`DLD_CFG_PULLDN];
        o_aux_pullup_en     <= i_aux_cfg_reg[`DLD_CFG_PULLUP];
        o_aux_pulldn_en     <= i_aux_cfg_reg[`DLD_CFG_PULLDN];
        o_auto_retry_enable <= i_auto_retry_bit;
        o_rx_enable         <= ~i_rx_disable_bit;
        o_aux_input_enable  <= ~i_aux_in_disable_bit;
        o_deglitch_enable   <= ~i_deglitch_disable_bit;
        o_blank_cycles      <= i_blank_cycles_cfg;
        o_serial_slave_active <= ~shared_uart;
        o_uart_active         <= shared_uart | ~i_shared_port_enable;
      end
      o_alert_overcurrent_n <= ~i_fault_alert;
      o_lamp_on <= lamp_pin | i_lamp_force_bit;
    end
  end

endmodule
`default_nettype wire

// [dld_line_driver_control_properties.sv]
/* checker for the line driver control block.
   assumes one clock and a bind onto the block's top module. */
`timescale 1ns/1ps
`default_nettype none
module dld_props #(
  parameter BLANK_CYCLES = 2560
) (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_interface_select,
  input wire logic        i_clock_enable_limit_pin,
  input wire logic        i_lamp_input,
  input wire logic [3:0]  i_line_cfg_reg,
  input wire logic        i_line_driver_off,
  input wire logic        i_line_level_bit,
  input wire logic        i_shared_port_enable,
  input wire logic        i_lamp_force_bit,
  input wire logic        i_fault_alert,
  input wire logic        o_line_drive,
  input wire logic        o_line_oe_n,
  input wire logic        o_line_pullup_en,
  input wire logic        o_line_pulldn_en,
  input wire logic        o_line_power_down,
  input wire logic        o_rx_enable,
  input wire logic        o_aux_input_enable,
  input wire logic        o_deglitch_enable,
  input wire logic        o_auto_retry_enable,
  input wire logic [15:0] o_blank_cycles,
  input wire logic        o_alert_overcurrent_n,
  input wire logic        o_lamp_on
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // strap control pins the fixed settings
  strap_fixed_a: assert property (!i_interface_select [*5] |->
    o_rx_enable && o_aux_input_enable && o_deglitch_enable) else $error("fixed enable lost");
  strap_pulls_a: assert property (!i_interface_select [*5] |->
    !o_line_pullup_en && !o_line_pulldn_en && !o_auto_retry_enable) else $error("pull on");
  strap_blank_a: assert property (!i_interface_select [*5] |->
    o_blank_cycles == BLANK_CYCLES) else $error("blanking wrong");
  transmit_drive_enable_off_a: assert property ((!i_interface_select && !i_clock_enable_limit_pin) [*5] |->
    o_line_oe_n) else $error("line driven without enable");
  // serial control driver bits
  drv_off_a: assert property ((i_interface_select && i_line_driver_off) [*5] |->
    o_line_oe_n && o_line_power_down) else $error("disabled driver active");
  lvl_high_a: assert property ((i_interface_select && !i_shared_port_enable &&
    !i_line_driver_off && i_line_level_bit && !i_line_cfg_reg[0]) [*5] |->
    !o_line_oe_n && o_line_drive) else $error("level bit not driven high");
  // lamp and alert
  lamp_force_a: assert property (i_lamp_force_bit [*2] |-> o_lamp_on)
    else $error("forced lamp off");
  lamp_off_a: assert property ((!i_lamp_input && !i_lamp_force_bit) [*5] |-> !o_lamp_on)
    else $error("lamp on without cause");
  alert_on_a: assert property (i_fault_alert [*3] |-> !o_alert_overcurrent_n)
    else $error("alert missing");
  cover property (o_lamp_on);
  cover property (!o_line_oe_n && o_line_drive);
  cover property (!o_alert_overcurrent_n);
endmodule
bind dld_line_driver_control dld_props #(.BLANK_CYCLES(BLANK_CYCLES)) i_dld_props (.*);
`default_nettype wire

// [dld_host_model.sv]
/* host pin model: transmit enable, transmit and aux level pins.
   assumes the bench picks the host's usage mode each cycle. */
`timescale 1ns/1ps
`default_nettype none
module dld_host_model (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_en,
  input  wire logic       i_tx,
  input  wire logic       i_lvl,
  input  wire logic       i_role,
  output var  logic       o_transmit_drive_enable,
  output var  logic       o_tx,
  output var  logic       o_lvl,
  output var  logic       o_role
);
  // role select held low unless shared variant 1 (mode 3) is in use
  always @(posedge i_clk) begin
    o_role <= (i_mode == 2'h3) && i_role;
  end
  // pins change just after the edge
  always @(posedge i_clk) begin
    case (i_mode)
      2'h1: {o_transmit_drive_enable, o_tx, o_lvl} <= 3'h7;
      2'h2: {o_transmit_drive_enable, o_tx, o_lvl} <= {2'h1, i_lvl};
      default: {o_transmit_drive_enable, o_tx, o_lvl} <= {i_en, i_tx, i_lvl};
    endcase
  end
endmodule
`default_nettype wire

// [dld_line_driver_control_test.sv]
/* self-checking bench for the line driver control block.
   assumes the host pin model and the checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module dld_line_driver_control_test;
  localparam BLK = 16;
  logic i_clk, i_srst, i_interface_select, i_select_or_totem_strap, i_lamp_input;
  logic [3:0] i_line_cfg_reg, i_aux_cfg_reg;
  logic [15:0] i_blank_cycles_cfg;
  logic i_line_driver_off, i_line_level_bit, i_aux_driver_off, i_aux_level_bit;
  logic i_shared_port_enable, i_shared_port_variant, i_lamp_force_bit, i_fault_alert;
  logic i_rx_disable_bit, i_aux_in_disable_bit, i_deglitch_disable_bit, i_auto_retry_bit;
  logic [1:0] mode;
  logic en, tx, lvl, role;
  wire i_clock_enable_limit_pin, i_serial_in_sink_strap, i_aux_level_in, i_serial_role_select;
  wire o_line_drive, o_line_oe_n, o_line_pullup_en, o_line_pulldn_en, o_line_power_down;
  wire o_aux_drive, o_aux_oe_n, o_aux_pullup_en, o_aux_pulldn_en, o_aux_power_down;
  wire o_rx_enable, o_aux_input_enable, o_deglitch_enable, o_auto_retry_enable;
  wire [15:0] o_blank_cycles;
  wire o_serial_slave_active, o_uart_active, o_alert_overcurrent_n, o_lamp_on;
  int errors, n_tests;
  dld_line_driver_control #(.BLANK_CYCLES(BLK)) i_dld_line_driver_control (.*);
  dld_host_model i_dld_host_model (.i_clk(i_clk), .i_mode(mode), .i_en(en), .i_tx(tx),
    .i_lvl(lvl), .i_role(role), .o_transmit_drive_enable(i_clock_enable_limit_pin), .o_tx(i_serial_in_sink_strap),
    .o_lvl(i_aux_level_in), .o_role(i_serial_role_select));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // expected {oe_n, level} of one driver
  function automatic logic [1:0] drv(input logic pp, sink, on, lev);
    logic d;
    d = on && (pp || (lev ? !sink : sink));
    return {!d, d & lev};
  endfunction
  // strap control: every strap and pin pattern, register bits ignored
  task t_strap;
    @(posedge i_clk);
    {i_rx_disable_bit, i_aux_in_disable_bit, i_deglitch_disable_bit, i_auto_retry_bit} <= 4'hF;
    {i_line_cfg_reg, i_aux_cfg_reg, i_blank_cycles_cfg} <= 24'hCC0005;
    for (int k = 0; k < 16; k++) begin
      @(posedge i_clk);
      {i_select_or_totem_strap, en, tx, lvl} <= k[3:0];
      cyc(6);
      chk({o_rx_enable, o_aux_input_enable, o_deglitch_enable}, 3'h7);
      chk({o_line_pullup_en, o_line_pulldn_en, o_aux_pullup_en, o_aux_pulldn_en,
        o_auto_retry_enable}, 5'h00);
      chk(o_blank_cycles, BLK);
      chk({o_line_oe_n, o_line_drive & !o_line_oe_n},
        drv(k[3], !k[3] && k[1], k[2], !k[1]));
      chk({o_aux_oe_n, o_aux_drive & !o_aux_oe_n}, drv(k[3], !k[3] && k[1], 1'b1, !k[0]));
    end
  endtask
  // serial control, pins held high, drivers set by bits
  task t_serial;
    @(posedge i_clk);
    i_interface_select <= 1'b1;
    mode <= 2'h1;
    for (int k = 0; k < 12; k++) begin
      @(posedge i_clk);
      {i_line_driver_off, i_line_level_bit, i_aux_driver_off, i_aux_level_bit} <= {2{k[1:0]}};
      {i_line_cfg_reg, i_aux_cfg_reg} <= {k[1:0], k[3:2], ~k[1:0], k[3:2]};
      cyc(6);
      chk({o_line_pulldn_en, o_line_pullup_en, o_aux_pulldn_en, o_aux_pullup_en},
        {k[1:0], ~k[1:0]});
      chk({o_line_power_down, o_aux_power_down}, {2{k[1]}});
      chk({o_line_oe_n, o_line_drive & !o_line_oe_n, o_aux_oe_n, o_aux_drive & !o_aux_oe_n},
        {2{drv(k[3], k[2], !k[1], k[0])}});
    end
  endtask
  // serial control, line follows the transmit pins
  task t_uart;
    @(posedge i_clk);
    {i_line_driver_off, i_line_level_bit, i_line_cfg_reg} <= 6'h02;
    {mode, en} <= 3'h1;
    for (int t = 0; t < 2; t++) begin
      @(posedge i_clk);
      tx <= t[0];
      cyc(6);
      chk({o_line_oe_n, o_line_drive, o_uart_active}, {1'b0, !t[0], 1'b1});
    end
  endtask
  // shared port, variant 0 roles and alert during uart
  task t_shared;
    @(posedge i_clk);
    {mode, i_shared_port_enable} <= 3'h5;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      {i_select_or_totem_strap, i_fault_alert} <= k[1:0];
      cyc(6);
      chk({o_serial_slave_active, o_uart_active, o_alert_overcurrent_n},
        {!k[1], k[1], !k[0]});
      chk(o_line_oe_n, 1'b1);
    end
  endtask
  // shared port, variant 1: role pin chooses, falling edge latches transmit pins
  task t_variant1;
    @(posedge i_clk);
    {mode, en, tx, i_shared_port_variant} <= 5'h1D;
    role <= 1'b1;
    cyc(6);
    chk({o_serial_slave_active, o_uart_active, o_line_oe_n, o_line_drive}, 4'h5);
    @(posedge i_clk);
    role <= 1'b0;
    @(posedge i_clk);
    tx <= 1'b1;
    cyc(6);
    chk({o_serial_slave_active, o_uart_active, o_line_oe_n, o_line_drive}, 4'h9);
    @(posedge i_clk);
    en <= 1'b0;
    cyc(6);
    chk({o_serial_slave_active, o_uart_active, o_line_oe_n, o_line_drive}, 4'h9);
  endtask
  // lamp gate over input and force bit
  task t_lamp;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      {i_lamp_input, i_lamp_force_bit} <= k[1:0];
      cyc(6);
      chk(o_lamp_on, |k[1:0]);
    end
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // hang guard
  initial begin
    #200000;
    errors++;
    test_done;
  end
  initial begin
    {i_srst, i_interface_select, i_select_or_totem_strap, i_lamp_input} = 4'h8;
    {i_line_cfg_reg, i_aux_cfg_reg, i_blank_cycles_cfg, mode, en, tx, lvl} = 29'h0;
    {i_line_driver_off, i_line_level_bit, i_aux_driver_off, i_aux_level_bit} = 4'h0;
    {i_shared_port_enable, i_shared_port_variant, i_lamp_force_bit, i_fault_alert} = 4'h0;
    {i_rx_disable_bit, i_aux_in_disable_bit, i_deglitch_disable_bit, i_auto_retry_bit} = 4'h0;
    role = 1'b0;
    errors = 0;
    n_tests = 0;
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    t_strap;
    t_serial;
    t_uart;
    t_shared;
    t_variant1;
    t_lamp;
    test_done;
  end
endmodule
`default_nettype wire
